/* verilog/bcc_consts.svh */
// Constants of the bridge command register block: offset, fields, reset, timing
// Assumes inclusion by bare name from the package and design modules
// Function
// - Command bits 15:11 read zero and ignore writes.
// - Interrupt disable bit 10 is read-only zero; bridge raises no interrupts.
// - Back-to-back enable bit 9 reads zero; never issues back-to-back cycles.
// - System error reporting bit 8 gates error messages for secondary SERR.
// - Stepping control bit 7 is hardwired zero.
// - Parity response bit 6 gates setting master data parity flag on poison.
// - Poisoned downstream data always goes to PCI with bad parity.
// - Palette snoop enable bit 5 reads zero.
// - Promote bit 4 turns memory writes into write-and-invalidate cycles.
// - Special cycle bit 3 reads zero; special cycles are never answered.
// - Upstream initiation on PCI Express only while bus initiator bit is one.
// - Bus initiator zero: secondary memory and I/O cycles get no response.
// - Bus initiator one: secondary memory and I/O may be forwarded upstream.
// - Memory space zero: downstream memory requests get unsupported request.
// - Memory space one: downstream memory requests accepted and forwarded.
// - I/O space zero: downstream I/O requests get unsupported request.
// - I/O space one: downstream I/O requests accepted and forwarded.
// - Signaled system error flag sets on error message while reporting enabled.
// - Master data parity flag sets on poisoned completion or poisoned write.
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH
`define BCC_CMD_OFFSET 8'h04
`define BCC_STATUS_OFFSET 8'h06
`define BCC_CMD_RESET 16'h0000
`define BCC_CMD_WMASK 16'h0157
`define BCC_BIT_SERR 8
`define BCC_BIT_PERR 6
`define BCC_BIT_MWI 4
`define BCC_BIT_MASTER 2
`define BCC_BIT_MEM 1
`define BCC_BIT_IO 0
`define BCC_STS_SYSERR 14
`define BCC_STS_MASTER_DATA_PARITY_FLAG 8
`define BCC_STS_RESET 16'h0000
`define BCC_SYNC_STAGES 3
`endif

/* verilog/bcc_pkg.sv */
// Types shared by the bridge command register block
// Assumes bcc_consts.svh on the include path
`include "bcc_consts.svh"
package bcc_pkg;
  // Downstream request kinds from the PCI Express receiver
  typedef enum logic [1:0] {BCC_REQ_MEM, BCC_REQ_IO, BCC_REQ_CFG, BCC_REQ_OTHER} bcc_req_kind_t;
  // Configuration access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } bcc_cfg_req_t;
  // Enable outputs toward the datapaths
  typedef struct packed {
    logic serr_report;
    logic parity_resp;
    logic promote_mwi;
    logic initiator;
    logic mem_space;
    logic io_space;
  } bcc_enables_t;
endpackage

/* verilog/bcc_sync.sv */
// Three-stage synchroniser with agreement filter for an outside level
// Assumes one clock; the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module bcc_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1;
  logic s2;
  logic s3;
  // Shift chain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Accept a change once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b0;
    end else if (s2 == s3) begin
      q_o <= s3;
    end
  end
endmodule
`default_nettype wire

/* verilog/bcc_decide.sv */
// Downstream request decision: forward or unsupported request
// Assumes same-clock request strobe from the receiver
`timescale 1ns/1ps
`default_nettype none
module bcc_decide
  import bcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire bcc_pkg::bcc_req_kind_t req_kind_i,
  input wire logic mem_en_i,
  input wire logic io_en_i,
  output logic fwd_o,
  output logic ur_o
);
  // Registered one-cycle verdict per memory or I/O request; none for other kinds
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwd_o <= 1'b0;
      ur_o <= 1'b0;
    end else begin
      fwd_o <= 1'b0;
      ur_o <= 1'b0;
      if (req_valid_i) begin
        unique case (req_kind_i)
          BCC_REQ_MEM: begin
            fwd_o <= mem_en_i;
            ur_o <= !mem_en_i;
          end
          BCC_REQ_IO: begin
            fwd_o <= io_en_i;
            ur_o <= !io_en_i;
          end
          BCC_REQ_CFG, BCC_REQ_OTHER: begin
            fwd_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/bcc_top.sv */
// Command register of the PCI Express to PCI bridge, with its gating logic
// Assumes a same-clock configuration port and same-clock datapath events;
// the secondary SERR pin comes from outside and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.svh"
module bcc_top
  import bcc_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire bcc_pkg::bcc_cfg_req_t CFG_REQ_I,
  output bcc_pkg::bcc_enables_t ENABLES_O,
  output logic [15:0] CFG_RDATA_O,
  output logic CFG_RVALID_O,
  input wire logic DN_REQ_VALID_I,
  input wire bcc_pkg::bcc_req_kind_t DN_REQ_KIND_I,
  output logic DN_FWD_O,
  output logic DN_UR_O,
  input wire logic DN_WRITE_I,
  input wire logic DN_POISON_I,
  input wire logic CPL_POISON_I,
  output logic PCI_BAD_PARITY_O,
  output logic PCI_MWI_O,
  input wire logic SEC_REQ_VALID_I,
  output logic SEC_CLAIM_O,
  input wire logic UP_REQ_I,
  output logic UP_GO_O,
  input wire logic SERR_N_I,
  output logic ERR_MSG_O,
  input wire logic SPECIAL_CYCLE_I,
  output logic SPECIAL_CLAIM_O,
  input wire logic STS_CLR_SYSERR_I,
  input wire logic STS_CLR_MASTER_DATA_PARITY_FLAG_I,
  output logic SIGNALED_SYSTEM_ERROR_FLAG_O,
  output logic MASTER_DATA_PARITY_FLAG_O
);
  logic [15:0] cmd;
  logic [15:0] next_cmd;
  logic [15:0] byte_mask;
  logic serr_sync;
  logic serr_prev;
  logic serr_fall;
  logic err_msg;
  logic poison_event;
  logic dn_fwd;
  logic dn_ur;

  // Expand byte enables into a bit mask
  function automatic logic [15:0] bcc_be_mask(input logic [1:0] be);
    bcc_be_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Write merge: only the writable enable bits change
  always_comb begin
    byte_mask = bcc_be_mask(CFG_REQ_I.be) & `BCC_CMD_WMASK;
    next_cmd = (cmd & ~byte_mask) | (CFG_REQ_I.wdata & byte_mask);
  end

  // Command register storage
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmd <= `BCC_CMD_RESET;
    end else if (CFG_REQ_I.wr && CFG_REQ_I.addr == `BCC_CMD_OFFSET) begin
      cmd <= next_cmd;
    end
  end

  // Read port: command and status words, zero elsewhere
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CFG_RDATA_O <= 16'h0000;
      CFG_RVALID_O <= 1'b0;
    end else begin
      CFG_RVALID_O <= CFG_REQ_I.rd;
      if (CFG_REQ_I.rd && CFG_REQ_I.addr == `BCC_CMD_OFFSET) begin
        CFG_RDATA_O <= cmd & `BCC_CMD_WMASK;
      end else if (CFG_REQ_I.rd && CFG_REQ_I.addr == `BCC_STATUS_OFFSET) begin
        CFG_RDATA_O <= 16'h0000;
        CFG_RDATA_O[`BCC_STS_SYSERR] <= SIGNALED_SYSTEM_ERROR_FLAG_O;
        CFG_RDATA_O[`BCC_STS_MASTER_DATA_PARITY_FLAG] <= MASTER_DATA_PARITY_FLAG_O;
      end else begin
        CFG_RDATA_O <= 16'h0000;
      end
    end
  end

  // Enable outputs registered from the command bits
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ENABLES_O <= '0;
    end else begin
      ENABLES_O.serr_report <= cmd[`BCC_BIT_SERR];
      ENABLES_O.parity_resp <= cmd[`BCC_BIT_PERR];
      ENABLES_O.promote_mwi <= cmd[`BCC_BIT_MWI];
      ENABLES_O.initiator <= cmd[`BCC_BIT_MASTER];
      ENABLES_O.mem_space <= cmd[`BCC_BIT_MEM];
      ENABLES_O.io_space <= cmd[`BCC_BIT_IO];
    end
  end

  // Downstream memory and I/O verdicts
  bcc_decide u_decide (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .req_valid_i(DN_REQ_VALID_I),
    .req_kind_i(DN_REQ_KIND_I),
    .mem_en_i(cmd[`BCC_BIT_MEM]),
    .io_en_i(cmd[`BCC_BIT_IO]),
    .fwd_o(dn_fwd),
    .ur_o(dn_ur)
  );

  // Verdict outputs retimed so they come from top-level flops
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DN_FWD_O <= 1'b0;
      DN_UR_O <= 1'b0;
    end else begin
      DN_FWD_O <= dn_fwd;
      DN_UR_O <= dn_ur;
    end
  end

  // Downstream request handling: bad parity on any poisoned request, promotion of memory writes
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PCI_BAD_PARITY_O <= 1'b0;
      PCI_MWI_O <= 1'b0;
    end else begin
      PCI_BAD_PARITY_O <= DN_REQ_VALID_I && DN_POISON_I;
      PCI_MWI_O <= DN_REQ_VALID_I && DN_WRITE_I && DN_REQ_KIND_I == BCC_REQ_MEM
                   && cmd[`BCC_BIT_MEM] && cmd[`BCC_BIT_MWI];
    end
  end

  // Secondary side and upstream initiation gating
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SEC_CLAIM_O <= 1'b0;
      UP_GO_O <= 1'b0;
      SPECIAL_CLAIM_O <= 1'b0;
    end else begin
      SEC_CLAIM_O <= SEC_REQ_VALID_I && cmd[`BCC_BIT_MASTER];
      UP_GO_O <= UP_REQ_I && cmd[`BCC_BIT_MASTER];
      SPECIAL_CLAIM_O <= 1'b0;
    end
  end

  // Secondary SERR pin synchroniser; pin inverted so idle matches the flops' reset level
  bcc_sync u_serr_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .d_i(!SERR_N_I),
    .q_o(serr_sync)
  );

  // Edge detect on the filtered SERR level; no false edge after reset
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      serr_prev <= 1'b0;
    end else begin
      serr_prev <= serr_sync;
    end
  end

  assign serr_fall = serr_sync && !serr_prev;
  assign err_msg = serr_fall && cmd[`BCC_BIT_SERR];
  assign poison_event = (CPL_POISON_I || (DN_REQ_VALID_I && DN_WRITE_I && DN_POISON_I))
                        && cmd[`BCC_BIT_PERR];

  // Error message request pulse
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ERR_MSG_O <= 1'b0;
    end else begin
      ERR_MSG_O <= err_msg;
    end
  end

  // Sticky status flags; a set beats a same-cycle clear
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SIGNALED_SYSTEM_ERROR_FLAG_O <= 1'b0;
    end else if (err_msg) begin
      SIGNALED_SYSTEM_ERROR_FLAG_O <= 1'b1;
    end else if (STS_CLR_SYSERR_I) begin
      SIGNALED_SYSTEM_ERROR_FLAG_O <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MASTER_DATA_PARITY_FLAG_O <= 1'b0;
    end else if (poison_event) begin
      MASTER_DATA_PARITY_FLAG_O <= 1'b1;
    end else if (STS_CLR_MASTER_DATA_PARITY_FLAG_I) begin
      MASTER_DATA_PARITY_FLAG_O <= 1'b0;
    end
  end

  // Assertions
  sequence s_mem_req_off;
    DN_REQ_VALID_I && DN_REQ_KIND_I == BCC_REQ_MEM && !cmd[`BCC_BIT_MEM];
  endsequence
  sequence s_io_req_off;
    DN_REQ_VALID_I && DN_REQ_KIND_I == BCC_REQ_IO && !cmd[`BCC_BIT_IO];
  endsequence
  sequence s_other_req;
    DN_REQ_VALID_I && (DN_REQ_KIND_I == BCC_REQ_CFG || DN_REQ_KIND_I == BCC_REQ_OTHER);
  endsequence
  sequence s_promote_write;
    DN_REQ_VALID_I && DN_WRITE_I && DN_REQ_KIND_I == BCC_REQ_MEM;
  endsequence
  sequence s_serr_report;
    serr_fall && cmd[`BCC_BIT_SERR];
  endsequence

  a_cmd_read_mask: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CFG_REQ_I.rd && CFG_REQ_I.addr == `BCC_CMD_OFFSET |=> (CFG_RDATA_O & 16'hfea8) == 16'h0000)
    else $error("command read shows a hardwired bit set");
  a_cmd_write_only: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CFG_REQ_I.wr && CFG_REQ_I.addr == `BCC_CMD_OFFSET && CFG_REQ_I.be == 2'b11
    |=> cmd == ($past(CFG_REQ_I.wdata) & `BCC_CMD_WMASK))
    else $error("command write did not take the writable bits only");
  a_mem_ur_off: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_mem_req_off |=> ##1 DN_UR_O && !DN_FWD_O)
    else $error("memory request not refused with mem space off");
  a_io_ur_off: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_io_req_off |=> ##1 DN_UR_O && !DN_FWD_O)
    else $error("io request not refused with io space off");
  a_mem_fwd_on: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    DN_REQ_VALID_I && DN_REQ_KIND_I == BCC_REQ_MEM && cmd[`BCC_BIT_MEM] |-> ##2 DN_FWD_O)
    else $error("memory request not forwarded with mem space on");
  a_io_fwd_on: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    DN_REQ_VALID_I && DN_REQ_KIND_I == BCC_REQ_IO && cmd[`BCC_BIT_IO] |-> ##2 DN_FWD_O)
    else $error("io request not forwarded with io space on");
  a_up_gate: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    UP_GO_O |-> $past(cmd[`BCC_BIT_MASTER]) && $past(UP_REQ_I))
    else $error("upstream initiation without initiator enable");
  a_sec_claim: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    SEC_REQ_VALID_I && !cmd[`BCC_BIT_MASTER] |=> !SEC_CLAIM_O)
    else $error("secondary cycle claimed with initiator off");
  a_bad_parity: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    DN_REQ_VALID_I && DN_POISON_I |=> PCI_BAD_PARITY_O)
    else $error("poisoned data not forwarded with bad parity");
  a_parity_flag: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(MASTER_DATA_PARITY_FLAG_O) |-> $past(cmd[`BCC_BIT_PERR]))
    else $error("parity flag set while parity response off");
  a_syserr_flag: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ERR_MSG_O |-> SIGNALED_SYSTEM_ERROR_FLAG_O)
    else $error("error message sent without system error flag");
  a_no_special: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    SPECIAL_CYCLE_I |=> !SPECIAL_CLAIM_O)
    else $error("special cycle answered");

  // Enables, promotion, initiator gating and bad parity
  a_enables_follow: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ENABLES_O == $past({cmd[`BCC_BIT_SERR], cmd[`BCC_BIT_PERR], cmd[`BCC_BIT_MWI],
                        cmd[`BCC_BIT_MASTER], cmd[`BCC_BIT_MEM], cmd[`BCC_BIT_IO]}))
    else $error("enable outputs do not follow the command bits");
  a_mwi_promote: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_promote_write ##0 (cmd[`BCC_BIT_MEM] && cmd[`BCC_BIT_MWI]) |=> PCI_MWI_O)
    else $error("memory write not promoted with promotion on");
  a_mwi_off: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !cmd[`BCC_BIT_MWI] |=> !PCI_MWI_O)
    else $error("write promoted with promotion off");
  a_sec_claim_on: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    SEC_REQ_VALID_I && cmd[`BCC_BIT_MASTER] |=> SEC_CLAIM_O)
    else $error("secondary cycle not taken with initiator on");
  a_up_go_on: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    UP_REQ_I && cmd[`BCC_BIT_MASTER] |=> UP_GO_O)
    else $error("upstream request held back with initiator on");
  a_bad_parity_off: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !(DN_REQ_VALID_I && DN_POISON_I) |=> !PCI_BAD_PARITY_O)
    else $error("bad parity forced on clean data");

  // Error reporting and status flags
  a_err_gate: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ERR_MSG_O |-> $past(cmd[`BCC_BIT_SERR]))
    else $error("error message sent with reporting off");
  a_err_report: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_serr_report |=> ERR_MSG_O && SIGNALED_SYSTEM_ERROR_FLAG_O)
    else $error("secondary error not reported with reporting on");
  a_par_set: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (CPL_POISON_I || DN_REQ_VALID_I && DN_WRITE_I && DN_POISON_I) && cmd[`BCC_BIT_PERR]
    |=> MASTER_DATA_PARITY_FLAG_O)
    else $error("parity flag not set on poisoned data");
  a_sys_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    STS_CLR_SYSERR_I && !err_msg |=> !SIGNALED_SYSTEM_ERROR_FLAG_O)
    else $error("system error flag not cleared");
  a_par_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    STS_CLR_MASTER_DATA_PARITY_FLAG_I && !poison_event |=> !MASTER_DATA_PARITY_FLAG_O)
    else $error("parity flag not cleared");
  a_status_read: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CFG_REQ_I.rd && CFG_REQ_I.addr == `BCC_STATUS_OFFSET
    |=> CFG_RDATA_O == {1'b0, $past(SIGNALED_SYSTEM_ERROR_FLAG_O), 5'h00,
                        $past(MASTER_DATA_PARITY_FLAG_O), 8'h00})
    else $error("status read does not show the flags");

  // Read port and downstream verdicts
  a_read_valid: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CFG_REQ_I.rd |=> CFG_RVALID_O)
    else $error("read not answered next cycle");
  a_fixed_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (cmd & ~`BCC_CMD_WMASK) == 16'h0000)
    else $error("read-only command bit stored as one");
  a_verdict_one: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !(DN_FWD_O && DN_UR_O))
    else $error("forward and unsupported given together");
  a_other_silent: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_other_req |=> ##1 !DN_FWD_O && !DN_UR_O)
    else $error("verdict given for a non memory, non io request");
endmodule
`default_nettype wire

/* bench/bcc_far_model.sv */
// Far-side model: PCI Express receiver events and the secondary PCI bus
// Assumes the bench calls its tasks from the falling edge of the shared clock
`timescale 1ns/1ps
`default_nettype none
module bcc_far_model
  import bcc_pkg::*;
(
  input wire logic clk_i,
  output logic dn_valid_o,
  output bcc_pkg::bcc_req_kind_t dn_kind_o,
  output logic dn_write_o,
  output logic dn_poison_o,
  output logic cpl_poison_o,
  output logic sec_valid_o,
  output logic up_req_o,
  output logic serr_n_o,
  output logic special_o
);
  // Idle levels; the error line is pulled up
  initial begin
    {dn_valid_o, dn_write_o, dn_poison_o} = 3'b000;
    dn_kind_o = BCC_REQ_OTHER;
    {cpl_poison_o, sec_valid_o, up_req_o, special_o} = 4'h0;
    serr_n_o = 1'b1;
  end
  // One downstream request held for one cycle
  task automatic dn_send(input bcc_req_kind_t kind, input logic wr, input logic psn);
    @(negedge clk_i);
    {dn_valid_o, dn_write_o, dn_poison_o} = {1'b1, wr, psn};
    dn_kind_o = kind;
    @(negedge clk_i);
    {dn_valid_o, dn_write_o, dn_poison_o} = {1'b0, ~wr, 1'b0};
    dn_kind_o = BCC_REQ_OTHER;
  endtask
  // One-cycle strobe: completion poison, secondary, upstream, special
  task automatic strobe(input logic [3:0] m);
    @(negedge clk_i);
    {cpl_poison_o, sec_valid_o, up_req_o, special_o} = m;
    @(negedge clk_i);
    {cpl_poison_o, sec_valid_o, up_req_o, special_o} = 4'h0;
  endtask
  // Error line level from the secondary bus
  task automatic serr_drive(input logic lvl);
    @(negedge clk_i);
    serr_n_o = lvl;
  endtask
endmodule
`default_nettype wire

/* bench/tb_bcc_top.sv */
// Self-checking bench for the bridge command register block
// Assumes bcc_pkg and the far-side model; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_bcc_top;
  import bcc_pkg::*;
  logic clk, rst_n, rvalid, clr_sys, clr_par;
  bcc_cfg_req_t cfg;
  bcc_enables_t en;
  logic [15:0] rdata;
  bcc_req_kind_t dn_kind;
  logic dn_valid, dn_write, dn_poison, cpl_poison, sec_valid, up_req, serr_n, special;
  logic fwd, ur, bad_par, mwi, claim, go, err_msg, sp_claim, f_sys, f_par;
  int n_fail, cmp_count;

  bcc_top i_bcc_top (.CLOCK_I(clk), .RST_N_I(rst_n), .CFG_REQ_I(cfg), .ENABLES_O(en),
    .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .DN_REQ_VALID_I(dn_valid),
    .DN_REQ_KIND_I(dn_kind), .DN_FWD_O(fwd), .DN_UR_O(ur), .DN_WRITE_I(dn_write),
    .DN_POISON_I(dn_poison), .CPL_POISON_I(cpl_poison), .PCI_BAD_PARITY_O(bad_par),
    .PCI_MWI_O(mwi), .SEC_REQ_VALID_I(sec_valid), .SEC_CLAIM_O(claim), .UP_REQ_I(up_req),
    .UP_GO_O(go), .SERR_N_I(serr_n), .ERR_MSG_O(err_msg), .SPECIAL_CYCLE_I(special),
    .SPECIAL_CLAIM_O(sp_claim), .STS_CLR_SYSERR_I(clr_sys), .STS_CLR_MASTER_DATA_PARITY_FLAG_I(clr_par),
    .SIGNALED_SYSTEM_ERROR_FLAG_O(f_sys), .MASTER_DATA_PARITY_FLAG_O(f_par));

  bcc_far_model i_bcc_far_model (.clk_i(clk), .dn_valid_o(dn_valid), .dn_kind_o(dn_kind),
    .dn_write_o(dn_write), .dn_poison_o(dn_poison), .cpl_poison_o(cpl_poison),
    .sec_valid_o(sec_valid), .up_req_o(up_req), .serr_n_o(serr_n), .special_o(special));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Verdict and end of run
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Config write, then one cycle for the enables to follow
  task automatic cfg_wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk);
    cfg = '{1'b1, 1'b0, a, be, d};
    @(negedge clk);
    cfg = '{1'b0, 1'b0, ~a, 2'b00, ~d};
    @(negedge clk);
  endtask

  // Config read; answer lands one cycle later
  task automatic cfg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    cfg = '{1'b0, 1'b1, a, 2'b11, 16'h0000};
    @(negedge clk);
    cfg = '{1'b0, 1'b0, ~a, 2'b00, 16'hffff};
    check({15'h0000, rvalid}, 16'h0001);
    check(rdata, exp);
  endtask

  // Downstream request: {bad parity, promote} next cycle, {forward, unsupported} after two
  task automatic dn(input bcc_req_kind_t k, input logic w, input logic p, input logic [3:0] e);
    logic [1:0] early;
    i_bcc_far_model.dn_send(k, w, p);
    early = {bad_par, mwi};
    @(negedge clk);
    check({12'h000, early, fwd, ur}, {12'h000, e});
  endtask

  // Status flag clear pulses
  task automatic clr(input logic s, input logic p);
    @(negedge clk);
    {clr_sys, clr_par} = {s, p};
    @(negedge clk);
    {clr_sys, clr_par} = 2'b00;
  endtask

  // Count error message pulses over a bounded span
  task automatic watch_err(input logic [15:0] exp);
    logic [15:0] seen;
    seen = 16'h0000;
    repeat (12) begin
      @(negedge clk);
      if (err_msg === 1'b1) seen++;
    end
    check(seen, exp);
  endtask

  // Main sequence
  initial begin
    {n_fail, cmp_count} = {32'd0, 32'd0};
    {rst_n, clr_sys, clr_par} = 3'b000;
    cfg = '0;
    repeat (10) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    check({10'h000, en}, 16'h0000);
    cfg_rd(8'h04, 16'h0000);
    cfg_rd(8'h06, 16'h0000);
    cfg_wr(8'h04, 2'b11, 16'hffff);
    cfg_rd(8'h04, 16'h0157);
    check({10'h000, en}, 16'h003f);
    cfg_wr(8'h04, 2'b01, 16'h0000);
    cfg_rd(8'h04, 16'h0100);
    cfg_wr(8'h08, 2'b11, 16'hffff);
    cfg_rd(8'h04, 16'h0100);
    cfg_rd(8'h08, 16'h0000);
    cfg_wr(8'h04, 2'b10, 16'hfeaa);
    cfg_rd(8'h04, 16'h0000);
    // Every kind under every memory and I/O enable pair
    for (int m = 0; m < 4; m++) begin
      cfg_wr(8'h04, 2'b11, {14'h0000, m[1:0]});
      for (int k = 0; k < 4; k++) begin
        dn(bcc_req_kind_t'(k), 1'b0, 1'b0, {2'b00, (k == 0 && m[1]) || (k == 1 && m[0]),
          (k == 0 && !m[1]) || (k == 1 && !m[0])});
      end
    end
    dn(BCC_REQ_MEM, 1'b1, 1'b1, 4'b1010);
    check({15'h0000, f_par}, 16'h0000);
    cfg_wr(8'h04, 2'b11, 16'h0053);
    check({10'h000, en}, 16'h001b);
    dn(BCC_REQ_MEM, 1'b1, 1'b0, 4'b0110);
    dn(BCC_REQ_MEM, 1'b1, 1'b1, 4'b1110);
    check({15'h0000, f_par}, 16'h0001);
    clr(1'b0, 1'b1);
    check({15'h0000, f_par}, 16'h0000);
    i_bcc_far_model.strobe(4'b1000);
    @(negedge clk);
    check({15'h0000, f_par}, 16'h0001);
    cfg_rd(8'h06, 16'h0100);
    clr(1'b0, 1'b1);
    cfg_wr(8'h04, 2'b11, 16'h0050);
    dn(BCC_REQ_MEM, 1'b1, 1'b0, 4'b0001);
    // Initiator gating and special cycles
    for (int b = 0; b < 2; b++) begin
      cfg_wr(8'h04, 2'b11, b ? 16'h0004 : 16'h0000);
      i_bcc_far_model.strobe(4'b0110);
      check({14'h0000, claim, go}, b ? 16'h0003 : 16'h0000);
      i_bcc_far_model.strobe(4'b0001);
      check({15'h0000, sp_claim}, 16'h0000);
    end
    // Secondary error reporting off, then on
    i_bcc_far_model.serr_drive(1'b0);
    watch_err(16'h0000);
    i_bcc_far_model.serr_drive(1'b1);
    repeat (8) @(negedge clk);
    check({15'h0000, f_sys}, 16'h0000);
    cfg_wr(8'h04, 2'b11, 16'h0104);
    check({10'h000, en}, 16'h0024);
    i_bcc_far_model.serr_drive(1'b0);
    watch_err(16'h0001);
    check({15'h0000, f_sys}, 16'h0001);
    i_bcc_far_model.serr_drive(1'b1);
    cfg_rd(8'h06, 16'h4000);
    clr(1'b1, 1'b0);
    cfg_rd(8'h06, 16'h0000);
    // Second reset in mid-run restores zeros
    @(negedge clk) rst_n = 1'b0;
    @(negedge clk) rst_n = 1'b1;
    check({10'h000, en}, 16'h0000);
    cfg_rd(8'h04, 16'h0000);
    test_done();
  end

  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #400us;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
